// ===== design/cps_sequencer.sv
// calibration pulse sequencer with APB register slave
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer #(
  // clock cycles per millisecond; a bench may shorten it to keep runs brief
  parameter int unsigned MS_CYCLES = cps_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // external digital triggers
  input wire logic [cps_pkg::NUM_TRIG-1:0] TRIGGER_IN,
  // injector driver commands
  output logic [cps_pkg::NUM_MODULES-1:0][cps_pkg::NUM_CHANNELS-1:0] INJ_CMD,
  // status
  output logic SEQUENCE_ACTIVE_FLAG,
  output logic [cps_pkg::PROG_W-1:0] SEQUENCE_PROGRESS_LEVEL
);
  import cps_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    cps_cfg_t cfg;
    cps_chan_t chan;
    cps_state_t fsm;
    logic [MS_W-1:0] ms_in_pulse;
    logic [CNT_W-1:0] done;
    logic [NUM_MODULES-1:0][NUM_CHANNELS-1:0] cmd;
    logic active;
    logic [PROG_W-1:0] prog;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cps_st_t;

  cps_st_t st_r, st_nxt;

  logic ms_tick;
  logic tick_restart;
  logic [NUM_TRIG-1:0] trig_lvl;
  logic [NUM_TRIG-1:0] trig_rise;

  cps_ms_tick #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .CLK(CLK),
    .RST_N(RST_N),
    .restart(tick_restart),
    .tick(ms_tick)
  );

  cps_trig_sync u_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .trig_in(TRIGGER_IN),
    .trig_lvl(trig_lvl),
    .trig_rise(trig_rise)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic acc;
  logic wr;
  logic start_wr;
  logic clear_wr;
  logic trig_start;
  logic start_req;
  logic [NUM_MODULES-1:0] mod_ok;
  logic [31:0] rd_mux;
  logic rd_err;

  // ready answers one cycle into the access phase
  assign acc = PSEL & PENABLE & ~st_r.pready;
  // a write lands only at the edge where the master sees ready
  assign wr = PSEL & PENABLE & PWRITE & st_r.pready;
  assign start_wr = wr & (PADDR == REG_CTRL) & PWDATA[CTRL_START_BIT];
  assign clear_wr = wr & (PADDR == REG_CTRL) & PWDATA[CTRL_CLEAR_BIT];
  // edges seen while running are dropped, never queued
  assign trig_start = st_r.cfg.trig_en & trig_rise[st_r.cfg.trig_sel];
  assign start_req = start_wr | trig_start;

  // module qualifies with exactly one channel and calibration mode
  always_comb begin
    for (int m = 0; m < NUM_MODULES; m++) begin
      mod_ok[m] = st_r.chan.cal_mode[m] & ($countones(st_r.chan.chan_en[m]) == 1);
    end
  end

  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    case (PADDR)
      REG_CTRL: begin
        rd_mux[CTRL_PAUSE_BIT] = st_r.cfg.pause;
      end
      REG_WIDTH: begin
        rd_mux[MS_W-1:0] = st_r.cfg.width_ms;
      end
      REG_INTERVAL: begin
        rd_mux[MS_W-1:0] = st_r.cfg.interval_ms;
      end
      REG_TOTAL: begin
        rd_mux[CNT_W-1:0] = st_r.cfg.total;
      end
      REG_TRIG: begin
        rd_mux[SEL_W-1:0] = st_r.cfg.trig_sel;
        rd_mux[TRIG_EN_BIT] = st_r.cfg.trig_en;
        rd_mux[TRIG_EN_BIT+1 +: NUM_TRIG] = trig_lvl;
      end
      REG_STATUS: begin
        rd_mux[STAT_ACTIVE_BIT] = st_r.active;
        rd_mux[STAT_PROG_LSB +: PROG_W] = st_r.prog;
      end
      REG_DONE: begin
        rd_mux[CNT_W-1:0] = st_r.done;
      end
      REG_CHAN: begin
        rd_mux[NUM_MODULES*NUM_CHANNELS-1:0] = st_r.chan.chan_en;
        rd_mux[CHAN_CAL_BIT +: NUM_MODULES] = st_r.chan.cal_mode;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [MS_W-1:0] width_eff;
  logic [MS_W-1:0] interval_eff;
  logic [MS_W-1:0] ms_next;
  logic [CNT_W+PROG_W-1:0] prog_num;
  logic count_met;
  logic in_gap;
  logic width_done;
  logic interval_done;
  logic rise_due;
  logic gap_hold;

  // an interval not longer than the width is stretched to width plus one
  assign width_eff = (st_r.cfg.width_ms == '0) ? MS_W'(1) : st_r.cfg.width_ms;
  assign interval_eff = (st_r.cfg.interval_ms > width_eff) ? st_r.cfg.interval_ms : width_eff + 1'b1;
  // the ms grid restarts at each start, so the first pulse is full width
  assign tick_restart = start_req & (st_r.fsm == CPS_IDLE);

  // ---------------------------------------------------------------
  // sequence conditions
  // ---------------------------------------------------------------
  // milliseconds since the last rise, counting the one ending now
  assign ms_next = st_r.ms_in_pulse + 1'b1;
  assign count_met = st_r.done >= st_r.cfg.total;
  // in the low state, zero only between a start and the first rise
  assign in_gap = st_r.ms_in_pulse != '0;
  // pause is not looked at here, so a pulse always runs its full width
  assign width_done = ms_tick & (ms_next >= width_eff);
  assign interval_done = ms_tick & (ms_next >= interval_eff);
  // first rise at once after a start, later ones one interval apart
  assign rise_due = ~count_met & ~st_r.cfg.pause & (~in_gap | interval_done);
  // paused past the interval end: park on its last ms, resume at next tick
  assign gap_hold = st_r.cfg.pause & (ms_next >= interval_eff);

  always_comb begin
    st_nxt = st_r;
    st_nxt.pready = acc;
    st_nxt.pslverr = acc & rd_err;
    if (acc & ~PWRITE) begin
      st_nxt.prdata = rd_mux;
    end
    if (wr) begin
      case (PADDR)
        REG_CTRL: begin
          st_nxt.cfg.pause = PWDATA[CTRL_PAUSE_BIT];
        end
        REG_WIDTH: begin
          st_nxt.cfg.width_ms = PWDATA[MS_W-1:0];
        end
        REG_INTERVAL: begin
          st_nxt.cfg.interval_ms = PWDATA[MS_W-1:0];
        end
        REG_TOTAL: begin
          st_nxt.cfg.total = PWDATA[CNT_W-1:0];
        end
        REG_TRIG: begin
          st_nxt.cfg.trig_sel = PWDATA[SEL_W-1:0];
          st_nxt.cfg.trig_en = PWDATA[TRIG_EN_BIT];
        end
        REG_CHAN: begin
          st_nxt.chan.chan_en = PWDATA[NUM_MODULES*NUM_CHANNELS-1:0];
          st_nxt.chan.cal_mode = PWDATA[CHAN_CAL_BIT +: NUM_MODULES];
        end
        default: begin
        end
      endcase
    end

    case (st_r.fsm)
      CPS_IDLE: begin
        // idle until a start with a nonzero total; a start with count met begins anew
        if (start_req && st_r.cfg.total != '0) begin
          st_nxt.fsm = CPS_LOW;
          st_nxt.ms_in_pulse = '0;
          st_nxt.active = 1'b1;
          if (st_r.done >= st_r.cfg.total) begin
            st_nxt.done = '0;
          end
        end
      end
      CPS_HIGH: begin
        if (ms_tick) begin
          st_nxt.ms_in_pulse = ms_next;
        end
        if (width_done) begin
          st_nxt.cmd = '0;
          st_nxt.fsm = CPS_LOW;
          st_nxt.done = st_r.done + 1'b1;
        end
      end
      CPS_LOW: begin
        if (count_met && in_gap) begin
          st_nxt.fsm = CPS_IDLE;
          st_nxt.active = 1'b0;
        end else if (ms_tick && in_gap) begin
          st_nxt.ms_in_pulse = ms_next;
        end
        if (rise_due) begin
          st_nxt.fsm = CPS_HIGH;
          st_nxt.ms_in_pulse = '0;
          for (int m = 0; m < NUM_MODULES; m++) begin
            st_nxt.cmd[m] = mod_ok[m] ? st_r.chan.chan_en[m] : '0;
          end
        end else if (gap_hold) begin
          // hold at the interval end while paused, resume at the next tick
          st_nxt.ms_in_pulse = interval_eff - 1'b1;
        end
      end
      default: begin
        st_nxt.fsm = CPS_IDLE;
      end
    endcase

    if (clear_wr) begin
      st_nxt.done = '0;
    end

    prog_num = (CNT_W+PROG_W)'(st_nxt.done) * (CNT_W+PROG_W)'((1 << PROG_W) - 1);
    if (st_r.cfg.total == '0) begin
      st_nxt.prog = '0;
    end else if (st_nxt.done >= st_r.cfg.total) begin
      // a total lowered below the count must not wrap the level
      st_nxt.prog = '1;
    end else begin
      st_nxt.prog = PROG_W'(prog_num / st_r.cfg.total);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
      st_r.cfg.width_ms <= WIDTH_RST;
      st_r.cfg.interval_ms <= INTERVAL_RST;
      st_r.cfg.total <= TOTAL_RST;
      st_r.fsm <= CPS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign INJ_CMD = st_r.cmd;
  assign SEQUENCE_ACTIVE_FLAG = st_r.active;
  assign SEQUENCE_PROGRESS_LEVEL = st_r.prog;
endmodule : cps_sequencer
`default_nettype wire

// ===== shared/cps_pkg.sv
// constants, register map and types for the calibration pulse sequencer
package cps_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_MODULES = 4;
  localparam int unsigned NUM_CHANNELS = 4;
  localparam int unsigned NUM_TRIG = 8;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned MS_W = 16;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PROG_W = 8;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned TICK_W = 17;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_WIDTH = 12'h004;
  localparam logic [11:0] REG_INTERVAL = 12'h008;
  localparam logic [11:0] REG_TOTAL = 12'h00C;
  localparam logic [11:0] REG_TRIG = 12'h010;
  localparam logic [11:0] REG_STATUS = 12'h014;
  localparam logic [11:0] REG_DONE = 12'h018;
  localparam logic [11:0] REG_CHAN = 12'h01C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_PAUSE_BIT = 1;
  localparam int unsigned CTRL_CLEAR_BIT = 2;
  localparam int unsigned TRIG_EN_BIT = 8;
  localparam int unsigned CHAN_CAL_BIT = 16;
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_PROG_LSB = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [MS_W-1:0] WIDTH_RST = 16'h0001;
  localparam logic [MS_W-1:0] INTERVAL_RST = 16'h000A;
  localparam logic [CNT_W-1:0] TOTAL_RST = 16'h0001;

  typedef enum logic [1:0] {
    CPS_IDLE,
    CPS_HIGH,
    CPS_LOW
  } cps_state_t;

  typedef struct packed {
    logic [MS_W-1:0] width_ms;
    logic [MS_W-1:0] interval_ms;
    logic [CNT_W-1:0] total;
    logic trig_en;
    logic [SEL_W-1:0] trig_sel;
    logic pause;
  } cps_cfg_t;

  typedef struct packed {
    logic [NUM_MODULES-1:0][NUM_CHANNELS-1:0] chan_en;
    logic [NUM_MODULES-1:0] cal_mode;
  } cps_chan_t;

endpackage : cps_pkg

// ===== design/cps_ms_tick.sv
// millisecond tick generator for the calibration pulse sequencer
`timescale 1ns/1ps
`default_nettype none
module cps_ms_tick #(
  // clock cycles per millisecond tick
  parameter int unsigned MS_CYCLES = cps_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // restart and tick
  input wire logic restart,
  output logic tick
);
  import cps_pkg::*;

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic tick;
  } cps_tick_st_t;

  cps_tick_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (restart) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == TICK_W'(MS_CYCLES - 1)) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule : cps_ms_tick
`default_nettype wire

// ===== design/cps_trig_sync.sv
// two-stage synchroniser with rising-edge detect for external triggers
`timescale 1ns/1ps
`default_nettype none
module cps_trig_sync (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // asynchronous trigger lines
  input wire logic [cps_pkg::NUM_TRIG-1:0] trig_in,
  // synchronised levels and rising edges
  output logic [cps_pkg::NUM_TRIG-1:0] trig_lvl,
  output logic [cps_pkg::NUM_TRIG-1:0] trig_rise
);
  import cps_pkg::*;

  typedef struct packed {
    logic [NUM_TRIG-1:0] s1;
    logic [NUM_TRIG-1:0] s2;
    logic [NUM_TRIG-1:0] s3;
  } cps_sync_st_t;

  cps_sync_st_t st_r, st_nxt;

  always_comb begin
    st_nxt.s1 = trig_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trig_lvl = st_r.s2;
  // edge taken between second and third stage only
  assign trig_rise = st_r.s2 & ~st_r.s3;
endmodule : cps_trig_sync
`default_nettype wire

// ===== testbench/cps_seq_monitor.sv
// concurrent checks on the calibration pulse sequencer ports
`timescale 1ns/1ps
`default_nettype none
module cps_seq_monitor #(
  parameter int unsigned MS_CYCLES = cps_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // triggers, commands, status
  input wire logic [cps_pkg::NUM_TRIG-1:0] TRIGGER_IN,
  input wire logic [cps_pkg::NUM_MODULES-1:0][cps_pkg::NUM_CHANNELS-1:0] INJ_CMD,
  input wire logic SEQUENCE_ACTIVE_FLAG,
  input wire logic [cps_pkg::PROG_W-1:0] SEQUENCE_PROGRESS_LEVEL
);
  import cps_pkg::*;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic take_w;
  logic cmd_any;
  logic pause_r;
  logic tot_nz_r;
  logic [31:0] hi_r;
  logic [31:0] lo_r;
  // writes land at the edge where ready is seen high
  assign take_w = PSEL && PENABLE && PWRITE && PREADY;
  assign cmd_any = |INJ_CMD;
  // host-side copies, so start and pause checks need no internal probes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pause_r <= 1'b0;
      tot_nz_r <= 1'b1;
      hi_r <= '0;
      lo_r <= '0;
    end else begin
      if (take_w && PADDR == REG_CTRL) pause_r <= PWDATA[CTRL_PAUSE_BIT];
      if (take_w && PADDR == REG_TOTAL) tot_nz_r <= |PWDATA[15:0];
      hi_r <= cmd_any ? hi_r + 32'h1 : '0;
      lo_r <= cmd_any ? '0 : lo_r + 32'h1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_one_chan_only: assert property ($onehot0(INJ_CMD[0]) && $onehot0(INJ_CMD[1])
    && $onehot0(INJ_CMD[2]) && $onehot0(INJ_CMD[3])) else $error("two channels of one module driven");
  a_cmd_in_run: assert property (cmd_any |-> SEQUENCE_ACTIVE_FLAG)
    else $error("command outside a sequence");
  a_start_runs: assert property (take_w && PADDR == REG_CTRL && PWDATA[CTRL_START_BIT]
    && !SEQUENCE_ACTIVE_FLAG && tot_nz_r |=> SEQUENCE_ACTIVE_FLAG) else $error("start not taken");
  a_width_full: assert property ($fell(cmd_any) |-> hi_r >= MS_CYCLES - 2)
    else $error("pulse cut short");
  a_idle_gap: assert property ($fell(SEQUENCE_ACTIVE_FLAG) |-> !cmd_any && lo_r >= 32'h1)
    else $error("run ended without low time");
  a_pause_holds: assert property (pause_r && $past(pause_r) |-> !$rose(cmd_any))
    else $error("new pulse while paused");
  a_clear_prog: assert property (take_w && PADDR == REG_CTRL && PWDATA[CTRL_CLEAR_BIT]
    |-> ##[1:3] SEQUENCE_PROGRESS_LEVEL == '0) else $error("clear left progress");
  a_end_full: assert property ($fell(SEQUENCE_ACTIVE_FLAG) |-> SEQUENCE_PROGRESS_LEVEL == 8'hFF)
    else $error("progress not full at end");
  a_ready_pulse: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle");
  a_err_unmapped: assert property (PREADY |-> PSLVERR == (PADDR > REG_CHAN))
    else $error("error response wrong");
  c_run: cover property ($rose(SEQUENCE_ACTIVE_FLAG));
  c_end: cover property ($fell(SEQUENCE_ACTIVE_FLAG));
  c_err: cover property (PSLVERR);
endmodule : cps_seq_monitor
bind cps_sequencer cps_seq_monitor #(.MS_CYCLES(MS_CYCLES)) u_cps_seq_monitor (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIGGER_IN(TRIGGER_IN),
  .INJ_CMD(INJ_CMD), .SEQUENCE_ACTIVE_FLAG(SEQUENCE_ACTIVE_FLAG),
  .SEQUENCE_PROGRESS_LEVEL(SEQUENCE_PROGRESS_LEVEL)
);
`default_nettype wire

// ===== testbench/cps_inj_model.sv
// receiving injector channels: counts pulses, times high and rise-to-rise
`timescale 1ns/1ps
`default_nettype none
module cps_inj_model (
  // clock and clear
  input wire logic CLK,
  input wire logic clr,
  // module m channel c at bit 4m+c
  input wire logic [15:0] cmd,
  // per-line figures in cycles
  output int rises [16],
  output int hi_len [16],
  output int gap [16]
);
  int hcnt [16];
  int pcnt [16];
  logic [15:0] cmd_q = '0;
  always @(posedge CLK) begin
    cmd_q <= cmd;
    for (int i = 0; i < 16; i++) begin
      hcnt[i] <= cmd[i] ? hcnt[i] + 1 : 0;
      pcnt[i] <= pcnt[i] + 1;
      if (clr) begin
        rises[i] <= 0;
      end else if (cmd[i] && !cmd_q[i]) begin
        rises[i] <= rises[i] + 1;
        gap[i] <= pcnt[i];
        pcnt[i] <= 1;
      end
      if (!cmd[i] && cmd_q[i]) hi_len[i] <= hcnt[i];
    end
  end
endmodule : cps_inj_model
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the calibration pulse sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  import cps_pkg::*;
  // a short millisecond keeps the whole run brief
  localparam int T = 100;
  logic CLK, rst_n, psel, penable, pwrite, pready, pslverr, clr, e, act;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic [7:0] trig, prog;
  logic [NUM_MODULES-1:0][NUM_CHANNELS-1:0] cmd;
  logic [1:0] ch;
  logic [2:0] sel;
  int rises [16], hi_len [16], gap [16];
  int miscompares, n_checks, seed, k;
  cps_sequencer #(.MS_CYCLES(T)) u_cps_sequencer (
    .CLK(CLK), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TRIGGER_IN(trig),
    .INJ_CMD(cmd), .SEQUENCE_ACTIVE_FLAG(act), .SEQUENCE_PROGRESS_LEVEL(prog)
  );
  cps_inj_model u_cps_inj_model (.CLK(CLK), .clr(clr), .cmd(cmd), .rises(rises), .hi_len(hi_len), .gap(gap));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic step(inout int n, input int lim);
    @(posedge CLK);
    n++;
    if (n > lim) begin
      miscompares++;
      final_report();
    end
  endtask : step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CLK);
    penable <= 1'b1;
    do step(n, 20); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse(input int i);
    trig <= 8'(1 << i);
    repeat (3) @(posedge CLK);
    trig <= 8'h00;
    repeat (6) @(posedge CLK);
  endtask : pulse
  task automatic clear_model();
    clr <= 1'b1;
    @(posedge CLK);
    clr <= 1'b0;
  endtask : clear_model
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 2694;
    {rst_n, psel, penable, pwrite, clr} = '0;
    paddr = '0;
    pwdata = '0;
    trig = '0;
    repeat (4) @(posedge CLK);
    `CHK("cmd_rst", '0, cmd)
    `CHK("act_rst", 1'b0, act)
    rst_n <= 1'b1;
    apb(0, REG_WIDTH, 0);
    `CHK("width_rst", WIDTH_RST, q[15:0])
    apb(0, REG_INTERVAL, 0);
    `CHK("interval_rst", INTERVAL_RST, q[15:0])
    apb(0, REG_TOTAL, 0);
    `CHK("total_rst", TOTAL_RST, q[15:0])
    apb(0, 12'hFFC, 0);
    `CHK("unmapped", 33'h100000000, {e, q})
    v = $random(seed);
    apb(1, REG_INTERVAL, v);
    apb(0, REG_INTERVAL, 0);
    `CHK("interval_rw", v[15:0], q[15:0])
    ch = 2'($random(seed));
    sel = 3'($random(seed));
    // module 1 has two channels, module 2 is not in calibration mode
    apb(1, REG_CHAN, 32'h0003_0030 | (32'h1 << ch) | (32'h100 << ch));
    apb(1, REG_WIDTH, 32'h1);
    apb(1, REG_INTERVAL, 32'h2);
    apb(1, REG_TOTAL, 32'h2);
    clear_model();
    apb(1, REG_CTRL, 32'h1);
    k = 0;
    while (act !== 1'b1) step(k, 4);
    k = 0;
    while (act !== 1'b0) step(k, 6 * T);
    `CHK("rises", 2, rises[ch])
    `CHK("multi_chan", 0, rises[4 + ch])
    `CHK("not_cal", 0, rises[8 + ch])
    `CHK("width", 1'b1, hi_len[ch] >= T - 2 && hi_len[ch] <= T + 2)
    `CHK("interval", 1'b1, gap[ch] >= 2 * T - 2 && gap[ch] <= 2 * T + 2)
    apb(0, REG_STATUS, 0);
    `CHK("status", 16'hFF00, q[15:0])
    apb(0, REG_DONE, 0);
    `CHK("done", 32'h2, q)
    apb(1, REG_CTRL, 32'h4);
    apb(0, REG_DONE, 0);
    `CHK("cleared", 32'h0, q)
    apb(1, REG_TRIG, {29'h0, sel});
    pulse(sel);
    `CHK("trig_off", 1'b0, act)
    apb(1, REG_TRIG, 32'h100 | sel);
    pulse(sel ^ 3'h1);
    `CHK("trig_other", 1'b0, act)
    clear_model();
    pulse(sel);
    `CHK("trig_on", 1'b1, act)
    k = 0;
    while (rises[ch] !== 1) step(k, 8);
    apb(1, REG_CTRL, 32'h2);
    k = 0;
    while (cmd !== '0) step(k, 2 * T);
    @(posedge CLK);
    `CHK("paused_width", 1'b1, hi_len[ch] >= T - 2 && hi_len[ch] <= T + 2)
    repeat (2 * T) @(posedge CLK);
    `CHK("paused_rises", 1, rises[ch])
    `CHK("paused_run", 1'b1, act)
    `CHK("half_prog", 8'h7F, prog)
    apb(1, REG_CTRL, 32'h0);
    k = 0;
    while (act !== 1'b0) step(k, 4 * T);
    `CHK("resumed", 2, rises[ch])
    apb(1, REG_TOTAL, 32'h0);
    apb(1, REG_CTRL, 32'h1);
    @(posedge CLK);
    `CHK("zero_total", 1'b0, act)
    final_report();
  end
endmodule : tb_top
`default_nettype wire
